/* design/mkps_params.svh */
// Purpose: Constants for the magnet key power switch controller.
// Assumes: 20 MHz system clock.
// Notes: Times are given in their own unit; cycle counts derive from them.
`ifndef MKPS_PARAMS_SVH
`define MKPS_PARAMS_SVH
`define MKPS_CLK_HZ 20000000
`define MKPS_HOLD_MS 1000
`define MKPS_HOLD_CYC ((`MKPS_CLK_HZ / 1000) * `MKPS_HOLD_MS)
`define MKPS_BLINK_MS 100
`define MKPS_BLINK_CYC ((`MKPS_CLK_HZ / 1000) * `MKPS_BLINK_MS)
`define MKPS_STATE_ON 1'h1
`define MKPS_STATE_OFF 1'h0
`endif

/* design/mkps_pkg.sv */
// Purpose: Types for the magnet key power switch controller.
// Assumes: Nothing beyond the parameter header.
// Notes: The struct mkps_nv_s is declared for the stored state; the controller carries it as one bit.
package mkps_pkg;
   typedef enum logic [1:0] {
      MKPS_INIT = 2'h0,
      MKPS_RUN = 2'h1
   } mkps_phase_e;

   typedef struct packed {
      logic valid;
      logic on;
   } mkps_nv_s;
endpackage

/* design/mkps_timer.sv */
// Purpose: Free counter that restarts while its run input is low.
// Assumes: One clock domain.
// Notes: The done pulse marks every completion of the interval.
`timescale 1ns/1ns
module mkps_timer #(
   parameter int unsigned COUNT = 20000000,
   parameter int unsigned WIDTH = 25
) (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic run_i,
   output logic done_o
);
   typedef struct packed {
      logic [WIDTH-1:0] cnt;
   } mkps_tmr_s;

   mkps_tmr_s st_q;
   mkps_tmr_s st_d;

   // Refused at elaboration, so an interval the counter cannot reach never builds.
   if (WIDTH > 63 || COUNT < 2 || COUNT >= (64'h1 << WIDTH)) begin : g_bad_count
      $error("mkps_timer: COUNT does not fit WIDTH");
   end

   always_comb begin
      st_d = st_q;
      if (!run_i || done_o) begin
         st_d.cnt = '0;
      end else begin
         st_d.cnt = st_q.cnt + WIDTH'(1);
      end
   end

   assign done_o = run_i && (st_q.cnt == WIDTH'(COUNT - 1));

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end
endmodule

/* design/mkps_ctrl.sv */
// Purpose: On/off controller driven by a magnet key sensor with a green indicator.
// Assumes: Inputs synchronous to clk_i; nonvolatile store external, read after reset release.
// Notes: The stored state is written whenever a hold toggles the on/off state.
//
// Overview of operation
// - Blink indicator while key is sensed with the module fitted, until a hold toggles.
// - Off plus one second hold turns on.
// - On plus one second hold turns off.
// - No switch module attached means on.
// - Keep state nonvolatile, resume after power.
`timescale 1ns/1ns
`include "mkps_params.svh"
module mkps_ctrl
   import mkps_pkg::*;
#(
   parameter int unsigned HOLD_CYC = `MKPS_HOLD_CYC,
   parameter int unsigned BLINK_CYC = `MKPS_BLINK_CYC
) (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic key_sensed_i,
   input wire logic module_present_i,
   input wire logic nv_on_i,
   output logic nv_we_o,
   output logic nv_on_o,
   output logic power_on_o,
   output logic led_o
);
   typedef struct packed {
      mkps_phase_e phase;
      logic on;
      logic blink;
      logic spent;
      logic nv_we;
      logic led;
      logic power;
   } mkps_st_s;

   mkps_st_s st_q;
   mkps_st_s st_d;
   logic hold_done;
   logic blink_tick;
   logic hold_run;

   // Stops once a touch has toggled, so a key left in place cannot flip the state back.
   assign hold_run = key_sensed_i && module_present_i && !st_q.spent && (st_q.phase == MKPS_RUN);

   mkps_timer #(.COUNT(HOLD_CYC), .WIDTH(32)) u_hold (
      .clk_i(clk_i),
      .rst_n_i(rst_n_i),
      .run_i(hold_run),
      .done_o(hold_done)
   );

   mkps_timer #(.COUNT(BLINK_CYC), .WIDTH(32)) u_blink (
      .clk_i(clk_i),
      .rst_n_i(rst_n_i),
      .run_i(key_sensed_i),
      .done_o(blink_tick)
   );

   always_comb begin
      st_d = st_q;
      st_d.nv_we = 1'b0;
      case (st_q.phase)
         MKPS_INIT: begin
            // Stored state is taken after reset release, never under reset.
            st_d.on = nv_on_i;
            st_d.phase = MKPS_RUN;
         end
         MKPS_RUN: begin
            if (hold_done) begin
               st_d.on = !st_q.on;
               st_d.nv_we = 1'b1;
               st_d.spent = 1'b1;
            end
         end
         default: begin
            st_d.phase = MKPS_INIT;
         end
      endcase
      // The key must leave, or the module be removed, before another hold is counted.
      if (!(key_sensed_i && module_present_i)) begin
         st_d.spent = 1'b0;
      end
      if (!key_sensed_i) begin
         st_d.blink = 1'b0;
      end else if (blink_tick) begin
         st_d.blink = !st_q.blink;
      end
      // After a toggle the indicator shows the new state steadily while the key stays.
      if (key_sensed_i && module_present_i && !st_d.spent) begin
         st_d.led = st_q.blink;
      end else begin
         st_d.led = st_d.on;
      end
      // A missing module must never leave the servos unpowered.
      st_d.power = st_d.on || !module_present_i;
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         st_q <= '{phase: MKPS_INIT, on: `MKPS_STATE_OFF, blink: 1'b0, spent: 1'b0,
                   nv_we: 1'b0, led: 1'b0, power: 1'b0};
      end else begin
         st_q <= st_d;
      end
   end

   assign nv_we_o = st_q.nv_we;
   assign nv_on_o = st_q.on;
   assign power_on_o = st_q.power;
   assign led_o = st_q.led;
endmodule

/* verif/mkps_ctrl_chk.sv */
// Purpose: Port checks for the magnet key controller.
// Assumes: Short sim counts, blink period 4.
// Notes: Windows leave slack for output registers.
`timescale 1ns/1ns
module mkps_ctrl_chk (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic key_sensed_i,
   input wire logic module_present_i,
   input wire logic nv_we_o,
   input wire logic nv_on_o,
   input wire logic power_on_o,
   input wire logic led_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);
   wire k = key_sensed_i && module_present_i;
   logic spent_q;
   wire spent = spent_q || nv_we_o;
   // Once a touch has toggled, blinking gives way to the steady state until the key leaves or the module is removed.
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         spent_q <= 1'b0;
      end else begin
         spent_q <= k && spent;
      end
   end
   AST_BLINK: assert property ((k && !spent && $stable(led_o))[*7] |=>
      !(k && !spent && $stable(led_o))) else $error("no blink");
   AST_STEADY: assert property (k && spent |-> led_o == nv_on_o)
      else $error("indicator not steady");
   AST_SHOW: assert property (!k[*2] |-> led_o == nv_on_o)
      else $error("indicator not state");
   AST_PULSE: assert property (nv_we_o |=> !nv_we_o) else $error("long write");
   AST_FOLLOW: assert property ((module_present_i && $stable(nv_on_o))[*3] |->
      power_on_o == nv_on_o) else $error("power off state");
   AST_ABSENT: assert property (!module_present_i[*3] |-> power_on_o && !nv_we_o)
      else $error("absent not on");
   AST_HOLD: assert property (!key_sensed_i[*4] |-> $stable(nv_on_o))
      else $error("change without key");
   cover property (nv_we_o);
   cover property (key_sensed_i && !module_present_i);
   cover property ($rose(power_on_o));
   cover property (k && spent);
endmodule
bind mkps_ctrl mkps_ctrl_chk chk_u (.*);

/* verif/mkps_store.sv */
// Purpose: Nonvolatile store on the switch module side.
// Assumes: Write strobe lasts one cycle.
// Notes: Never reset, so the state outlives a power cycle.
`timescale 1ns/1ns
module mkps_store (
   input wire logic clk_i,
   input wire logic we_i,
   input wire logic d_i,
   output logic q_o
);
   logic mem_q = 1'b0;
   always @(posedge clk_i) begin
      if (we_i) begin
         mem_q <= d_i;
      end
   end
   assign q_o = mem_q;
endmodule

/* verif/tb.sv */
// Purpose: Random and corner key holds on the controller.
// Assumes: Hold 20 cycles, blink 4 cycles.
// Notes: Holds avoid the exact count, whose edge is loosely fixed.
`timescale 1ns/1ns
module tb;
   localparam int HOLD = 20;
   localparam int BLINK = 4;
   logic clk_i = 1'b0, rst_n_i = 1'b0, key = 1'b0, mp = 1'b1, nv_q, we, nv_d, pwr, led;
   logic e = 1'b0;
   logic [7:0] r = 8'h0C;
   int error_cnt = 0, n_checks = 0;
   always #25 clk_i = ~clk_i;
   mkps_ctrl #(.HOLD_CYC(HOLD), .BLINK_CYC(BLINK)) dut_u (.clk_i(clk_i), .rst_n_i(rst_n_i),
      .key_sensed_i(key), .module_present_i(mp), .nv_on_i(nv_q), .nv_we_o(we),
      .nv_on_o(nv_d), .power_on_o(pwr), .led_o(led));
   mkps_store st_u (.clk_i(clk_i), .we_i(we), .d_i(nv_d), .q_o(nv_q));
   task automatic chk(input logic g, input logic w);
      n_checks++;
      if (g !== w) begin
         error_cnt++;
         $display("ERROR %0t mismatch", $time);
      end
   endtask
   function automatic logic [7:0] lfsr_next(input logic [7:0] v);
      return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
   endfunction
   // One touch toggles once, and only with the module fitted and a full hold.
   function automatic logic exp_state(input logic s, input int n, input logic p);
      return (p && n >= HOLD) ? ~s : s;
   endfunction
   // Needs n of at least BLINK + 2 so the key always drops on a clock edge.
   task automatic hold(input int n);
      @(posedge clk_i) key <= 1'b1;
      repeat (2) @(posedge clk_i);
      #1 chk(led, mp ? 1'b0 : e);
      repeat (BLINK - 1) @(posedge clk_i);
      #1 chk(led, mp ? 1'b1 : e);
      repeat (n - BLINK - 1) @(posedge clk_i);
      key <= 1'b0;
      repeat (8) @(posedge clk_i);
      e = exp_state(e, n, mp);
      #1 chk(nv_d, e);
      chk(pwr, e | ~mp);
      chk(led, e);
      $display("hold %0d done", n);
   endtask
   task automatic power_cycle();
      @(posedge clk_i) rst_n_i <= 1'b0;
      repeat (3) @(posedge clk_i);
      rst_n_i <= 1'b1;
      repeat (4) @(posedge clk_i);
      #1 chk(pwr, e);
      chk(nv_d, e);
      chk(led, e);
      $display("power cycle done");
   endtask
   task automatic test_done();
      $display("checks %0d errors %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   initial begin
      repeat (20) @(posedge clk_i);
      rst_n_i <= 1'b1;
      repeat (3) @(posedge clk_i);
      hold(25);
      hold(12);
      hold(30);
      for (int i = 0; i < 8; i++) begin
         r = lfsr_next(r);
         hold(r[0] ? 25 + r[3:1] : 6 + r[3:1]);
      end
      @(posedge clk_i) mp <= 1'b0;
      hold(25);
      @(posedge clk_i) mp <= 1'b1;
      hold(26);
      hold(27);
      if (!e) hold(25);
      chk(nv_q, e);
      power_cycle();
      hold(25);
      chk(nv_q, e);
      power_cycle();
      test_done();
   end
endmodule
